/* pll_regs_cfg.svh */
// register offsets, field positions and reset values of the loop register bank
`ifndef PLL_REGS_CFG_SVH
`define PLL_REGS_CFG_SVH
`define OFS_STATUS      2'h0
`define OFS_CONTROL     2'h1
`define OFS_PHASE       2'h2
`define BIT_LOCKED      0
`define BIT_PHASEDONE   1
`define BIT_LOOPRESET   0
`define BIT_PFDENABLE   1
`define RST_LOCKED      1'h1
`define RST_PHASEDONE   1'h0
`define RST_LOOPRESET   1'h0
`define RST_PFDENABLE   1'h1
`define CNT_SEL_W       9
`define PHASE_LSB       30
`define PHASE_NOP       2'h0
`define PHASE_UP        2'h1
`define PHASE_DOWN      2'h2
`define FULL_WIDTH      32
`define LEGACY_WIDTH    16
`endif

/* pll_regs_pkg.sv */
// types shared by the loop register bank files
package pll_regs_pkg;
  // register port request from software
  typedef struct packed {
    logic        read;
    logic        write;
    logic [1:0]  address;
    logic [31:0] writeData;
  } reg_req_s;
  // signals to the analogue loop
  typedef struct packed {
    logic       loopReset;
    logic       pfdEnable;
    logic       phaseStep;
    logic       phaseUpDown;
    logic [8:0] counterSel;
  } loop_ctl_s;
  typedef enum logic [1:0] {
    STEP_IDLE = 2'b00,
    STEP_WAIT = 2'b01
  } step_state_e;
endpackage

/* sync_bit.sv */
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sysClk,
  input  wire logic rstN,
  // level in and out
  input  wire logic din,
  output logic      dout
);
  logic stage1_r;
  logic stage2_r;
  // first stage feeds only the second
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end
  assign dout = stage2_r;
endmodule
`default_nettype wire

/* phase_step.sv */
// turns a phase field write into one step request held until done
`timescale 1ns/1ps
`default_nettype none
module phase_step (
  // clock and reset
  input  wire logic                   sysClk,
  input  wire logic                   rstN,
  // request from register write
  input  wire logic                   start,
  input  wire logic [1:0]             dir,
  // synchronised done from the loop
  input  wire logic                   doneSync,
  // step outputs
  output logic                        stepReq,
  output logic                        stepUp
);
  import pll_regs_pkg::*;
  `include "pll_regs_cfg.svh"
  step_state_e state_r, state_nxt;
  logic        up_r, up_nxt;
  // only 01 and 10 do anything; 00 and 11 are no-ops
  always_comb begin
    state_nxt = state_r;
    up_nxt    = up_r;
    unique case (state_r)
      STEP_IDLE: begin
        // a stale done from the last step would end a new step at once
        if (start && !doneSync && (dir == `PHASE_UP || dir == `PHASE_DOWN)) begin
          state_nxt = STEP_WAIT;
          up_nxt    = (dir == `PHASE_UP);
        end
      end
      STEP_WAIT: begin
        if (doneSync) begin
          state_nxt = STEP_IDLE;
        end
      end
      default: state_nxt = STEP_IDLE;
    endcase
  end
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      state_r <= STEP_IDLE;
      up_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      up_r    <= up_nxt;
    end
  end
  assign stepReq = (state_r == STEP_WAIT);
  assign stepUp  = up_r;
endmodule
`default_nettype wire

/* pll_status_control_regs.sv */
// register bank wrapping the phase-locked loop status and control signals
`timescale 1ns/1ps
`default_nettype none
module pll_status_control_regs #(
  parameter int unsigned REG_WIDTH    = 32,
  parameter bit          HAS_RESET    = 1'b1,
  parameter bit          RESET_MAPPED = 1'b1,
  parameter bit          HAS_PFD      = 1'b1,
  parameter bit          PFD_MAPPED   = 1'b1,
  parameter bit          HAS_LOCKED   = 1'b1,
  parameter bit          LOCKED_MAPPED = 1'b1,
  parameter bit          HAS_PHASE    = 1'b1,
  parameter bit          PHASE_MAPPED = 1'b1
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  // register port
  input  wire pll_regs_pkg::reg_req_s   regReq,
  output logic [31:0]                   readData,
  // loop side inputs, asynchronous to sys_clk
  input  wire logic                     loopLocked,
  input  wire logic                     loopPhaseDone,
  // exported request and enable inputs, used when not register-mapped
  input  wire logic                     extLoopReset,
  input  wire logic                     extPfdEnable,
  input  wire logic                     extLoopEnable,
  // loop side outputs
  output pll_regs_pkg::loop_ctl_s       loopCtl,
  output logic                          loopEnable,
  // raw conduits
  output logic                          lockedRaw,
  output logic                          phaseDoneRaw,
  // system reset request to enclosing module
  output logic                          systemResetReq
);
  import pll_regs_pkg::*;
  `include "pll_regs_cfg.svh"

  // refuse widths other than the two variants
  initial begin
    if (REG_WIDTH != `FULL_WIDTH && REG_WIDTH != `LEGACY_WIDTH) begin
      $error("REG_WIDTH must be 32 or 16");
    end
  end

  localparam bit FULL = (REG_WIDTH == `FULL_WIDTH);
  // full variant always holds the registers; legacy only when generated and mapped
  localparam bit MAP_LOCK  = FULL || (HAS_LOCKED && LOCKED_MAPPED);
  localparam bit MAP_PHASE = FULL || (HAS_PHASE && PHASE_MAPPED);
  localparam bit MAP_RST   = FULL || (HAS_RESET && RESET_MAPPED);
  localparam bit MAP_PFD   = FULL || (HAS_PFD && PFD_MAPPED);

  // reset release through two flip-flops
  logic rstMeta_r;
  logic rstN_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  // address decode used by the write path; the read path decodes the address in its own case
  function automatic logic hit(input reg_req_s r, input logic [1:0] ofs);
    hit = (r.address == ofs);
  endfunction

  // status inputs cross into sys_clk
  logic lockSync;
  logic doneSync;
  sync_bit #(.RESET_VAL(`RST_LOCKED)) u_syncLock (
    .sysClk (sys_clk),
    .rstN   (rstN_r),
    .din    (loopLocked),
    .dout   (lockSync)
  );
  sync_bit #(.RESET_VAL(`RST_PHASEDONE)) u_syncDone (
    .sysClk (sys_clk),
    .rstN   (rstN_r),
    .din    (loopPhaseDone),
    .dout   (doneSync)
  );

  // control and phase-select registers
  logic                  loopReset_r, loopReset_nxt;
  logic                  pfdEnable_r, pfdEnable_nxt;
  logic [`CNT_SEL_W-1:0] cntSel_r, cntSel_nxt;
  logic                  stepStart;
  logic [1:0]            stepDir;
  logic                  stepReq;
  logic                  stepUp;
  always_comb begin
    loopReset_nxt = loopReset_r;
    pfdEnable_nxt = pfdEnable_r;
    cntSel_nxt    = cntSel_r;
    stepStart     = 1'b0;
    stepDir       = regReq.writeData[`PHASE_LSB +: 2];
    // offset zero has no write branch, so writes there are dropped
    if (regReq.write && hit(regReq, `OFS_CONTROL)) begin
      if (MAP_RST) begin
        loopReset_nxt = regReq.writeData[`BIT_LOOPRESET];
      end
      if (MAP_PFD) begin
        pfdEnable_nxt = regReq.writeData[`BIT_PFDENABLE];
      end
    end
    // phase stepping exists only in the full variant; a write while a step
    // is still settling is refused so the counter cannot change mid-step
    if (FULL && regReq.write && hit(regReq, `OFS_PHASE) && !stepReq && !doneSync) begin
      cntSel_nxt = regReq.writeData[`CNT_SEL_W-1:0];
      stepStart  = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      loopReset_r <= `RST_LOOPRESET;
      pfdEnable_r <= `RST_PFDENABLE;
      cntSel_r    <= '0;
    end else begin
      loopReset_r <= loopReset_nxt;
      pfdEnable_r <= pfdEnable_nxt;
      cntSel_r    <= cntSel_nxt;
    end
  end

  // phase step sequencer
  phase_step u_step (
    .sysClk   (sys_clk),
    .rstN     (rstN_r),
    .start    (stepStart),
    .dir      (stepDir),
    .doneSync (doneSync),
    .stepReq  (stepReq),
    .stepUp   (stepUp)
  );

  // read data, registered; unmapped and reserved bits read zero
  logic [31:0] readData_r, readData_nxt;
  always_comb begin
    readData_nxt = '0;
    if (regReq.read) begin
      unique case (regReq.address)
        `OFS_STATUS: begin
          readData_nxt[`BIT_LOCKED]    = MAP_LOCK & lockSync;
          readData_nxt[`BIT_PHASEDONE] = MAP_PHASE & doneSync;
        end
        `OFS_CONTROL: begin
          readData_nxt[`BIT_LOOPRESET] = MAP_RST & loopReset_r;
          readData_nxt[`BIT_PFDENABLE] = MAP_PFD & pfdEnable_r;
        end
        `OFS_PHASE: begin
          if (FULL) begin
            readData_nxt[`CNT_SEL_W-1:0] = cntSel_r;
          end
        end
        default: readData_nxt = '0;
      endcase
      if (!FULL) begin
        readData_nxt[31:16] = '0;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      readData_r <= '0;
    end else begin
      readData_r <= readData_nxt;
    end
  end
  assign readData = readData_r;

  // loop side: register bit or exported input, per mapping choice
  logic resetSel;
  assign resetSel = MAP_RST ? loopReset_r : (HAS_RESET & extLoopReset);
  always_comb begin
    loopCtl.loopReset   = resetSel;
    loopCtl.pfdEnable   = MAP_PFD ? pfdEnable_r : (!HAS_PFD | extPfdEnable);
    loopCtl.phaseStep   = stepReq;
    loopCtl.phaseUpDown = stepUp;
    loopCtl.counterSel  = cntSel_r;
  end
  // enable is never mapped; it follows the exported input directly, with no default when unused
  assign loopEnable     = extLoopEnable;
  assign lockedRaw      = loopLocked;
  assign phaseDoneRaw   = loopPhaseDone;
  assign systemResetReq = resetSel;

  // a write to status must not disturb the control bits
  a_status_write_inert: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    (regReq.write && regReq.address == `OFS_STATUS)
    |=> $stable(loopReset_r) && $stable(pfdEnable_r))
    else $error("status write changed control state");
  // lock bit follows the synchronised level one cycle after a read
  a_lock_read: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    (regReq.read && regReq.address == `OFS_STATUS)
    |=> readData[`BIT_LOCKED] == (MAP_LOCK & $past(lockSync)))
    else $error("lock bit read mismatch");
  a_done_read: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    (regReq.read && regReq.address == `OFS_STATUS)
    |=> readData[`BIT_PHASEDONE] == (MAP_PHASE & $past(doneSync)))
    else $error("phase done bit read mismatch");
  a_raw_conduit: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    lockedRaw == loopLocked && phaseDoneRaw == loopPhaseDone)
    else $error("raw conduit mismatch");
  a_reset_write: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    (MAP_RST && regReq.write && regReq.address == `OFS_CONTROL)
    |=> loopCtl.loopReset == $past(regReq.writeData[`BIT_LOOPRESET]))
    else $error("loop reset not driven by control write");
  a_pfd_write: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    (MAP_PFD && regReq.write && regReq.address == `OFS_CONTROL)
    |=> loopCtl.pfdEnable == $past(regReq.writeData[`BIT_PFDENABLE]))
    else $error("detector enable not driven by control write");
  a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    (regReq.read && regReq.address == `OFS_CONTROL)
    |=> readData[1:0] == {MAP_PFD & $past(pfdEnable_r), MAP_RST & $past(loopReset_r)})
    else $error("control readback mismatch");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    $past(regReq.address) != `OFS_PHASE |-> readData[31:2] == '0)
    else $error("reserved bits not zero");
  a_sysreset_tie: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    systemResetReq == loopCtl.loopReset)
    else $error("system reset differs from loop reset");
  a_step_dir: assert property (@(posedge sys_clk) disable iff (!rstN_r)
    (FULL && stepStart && !stepReq && !doneSync && stepDir == `PHASE_DOWN)
    |=> stepReq && !stepUp)
    else $error("step down not issued");
endmodule
`default_nettype wire

/* pll_loop_model.sv */
// behavioural model of the analogue loop behind the register bank
`timescale 1ns/1ps
`default_nettype none
module pll_loop_model #(
  parameter int LOCK_DLY = 8,
  parameter int DONE_DLY = 4
) (
  // controls from the bank
  input  wire pll_regs_pkg::loop_ctl_s ctl,
  // indications back, asynchronous to the bank clock
  output logic                         locked,
  output logic                         phaseDone
);
  logic loopClk;
  int   lockCnt;
  int   doneCnt;
  // own free-running clock, unrelated in phase to the bank clock
  initial begin
    loopClk = 1'b0;
    locked = 1'b1;
    phaseDone = 1'b0;
    lockCnt = LOCK_DLY;
    doneCnt = 0;
    forever #3.5 loopClk = ~loopClk;
  end
  // reset request drops lock, which returns only after a relock time
  always @(posedge loopClk) begin
    if (ctl.loopReset) begin
      locked <= 1'b0;
      lockCnt <= 0;
    end else if (lockCnt < LOCK_DLY) begin
      lockCnt <= lockCnt + 1;
    end else begin
      locked <= 1'b1;
    end
  end
  // done rises some cycles into a step and falls once the request goes
  always @(posedge loopClk) begin
    if (!ctl.phaseStep) begin
      doneCnt <= 0;
      phaseDone <= 1'b0;
    end else if (doneCnt < DONE_DLY) begin
      doneCnt <= doneCnt + 1;
    end else begin
      phaseDone <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the loop register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pll_regs_pkg::*;
  logic        sysClk;
  logic        arstN;
  reg_req_s    req;
  logic [31:0] readData;
  logic        locked;
  logic        phaseDone;
  logic        extEn;
  loop_ctl_s   ctl;
  logic        loopEnable;
  logic        lockedRaw;
  logic        phaseDoneRaw;
  logic        sysRst;
  int          n_fail;
  int          num_checks;
  pll_status_control_regs DUT (.sys_clk(sysClk), .arst_n(arstN), .regReq(req),
    .readData(readData), .loopLocked(locked), .loopPhaseDone(phaseDone),
    .extLoopReset(1'b0), .extPfdEnable(1'b1), .extLoopEnable(extEn),
    .loopCtl(ctl), .loopEnable(loopEnable), .lockedRaw(lockedRaw),
    .phaseDoneRaw(phaseDoneRaw), .systemResetReq(sysRst));
  pll_loop_model loop (.ctl(ctl), .locked(locked), .phaseDone(phaseDone));
  initial begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one idle cycle between strobes keeps every drive to once per step
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge sysClk);
    #1;
    req.write = 1'b1;
    req.address = a;
    req.writeData = d;
    @(posedge sysClk);
    #1;
    req.write = 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] exp, input string name);
    @(posedge sysClk);
    #1;
    req.read = 1'b1;
    req.address = a;
    @(posedge sysClk);
    #1;
    req.read = 1'b0;
    chk(name, exp, readData);
  endtask
  // bounded wait for the pending step to finish
  task automatic waitStep();
    for (int i = 0; i < 60; i++) begin
      @(posedge sysClk);
      #1;
      if (ctl.phaseStep === 1'b0) break;
    end
    chk("stepEnd", 32'h0, {31'h0, ctl.phaseStep});
    // let the synchronised done fall before the next step write
    repeat (6) @(posedge sysClk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred nanoseconds the tests need
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end
  initial begin
    n_fail = 0;
    num_checks = 0;
    req = '0;
    arstN = 1'b0;
    extEn = 1'b1;
    repeat (5) @(posedge sysClk);
    #1;
    arstN = 1'b1;
    repeat (3) @(posedge sysClk);
    #1;
    // values after reset
    chk("loopReset", 32'h0, {31'h0, ctl.loopReset});
    chk("pfdEnable", 32'h1, {31'h0, ctl.pfdEnable});
    rd(2'h0, 32'h1, "status");
    rd(2'h1, 32'h2, "control");
    $display("test reset values done");
    // writes to status and the undefined slot change nothing
    wr(2'h0, 32'hffffffff);
    wr(2'h3, 32'hffffffff);
    rd(2'h0, 32'h1, "statusRo");
    rd(2'h1, 32'h2, "ctlKept");
    rd(2'h3, 32'h0, "slot3");
    $display("test read-only done");
    // loop reset request, detector enable, readback
    wr(2'h1, 32'h3);
    chk("loopReset1", 32'h1, {31'h0, ctl.loopReset});
    chk("sysReset", 32'h1, {31'h0, sysRst});
    repeat (10) @(posedge sysClk);
    #1;
    chk("lockRaw", {31'h0, locked}, {31'h0, lockedRaw});
    rd(2'h0, 32'h0, "unlocked");
    rd(2'h1, 32'h3, "ctlRead");
    wr(2'h1, 32'h0);
    chk("pfdOff", 32'h0, {31'h0, ctl.pfdEnable});
    chk("sysRel", 32'h0, {31'h0, sysRst});
    rd(2'h1, 32'h0, "ctlZero");
    wr(2'h1, 32'h2);
    repeat (25) @(posedge sysClk);
    #1;
    rd(2'h0, 32'h1, "relocked");
    extEn = 1'b0;
    #1;
    chk("enableOff", 32'h0, {31'h0, loopEnable});
    extEn = 1'b1;
    #1;
    chk("enableOn", 32'h1, {31'h0, loopEnable});
    $display("test control done");
    // step up, a refused second write while pending, then step down
    wr(2'h2, 32'h40000105);
    chk("stepUp", 32'h3, {30'h0, ctl.phaseStep, ctl.phaseUpDown});
    chk("counterSel", 32'h105, {23'h0, ctl.counterSel});
    wr(2'h2, 32'h80000003);
    chk("pendingKept", 32'h1, {31'h0, ctl.phaseUpDown});
    for (int i = 0; i < 60; i++) begin
      @(posedge sysClk);
      #1;
      if (phaseDone === 1'b1) break;
    end
    chk("doneRaw", 32'h1, {31'h0, phaseDoneRaw});
    waitStep();
    rd(2'h2, 32'h105, "phaseRead");
    wr(2'h2, 32'h80000000);
    chk("stepDown", 32'h2, {30'h0, ctl.phaseStep, ctl.phaseUpDown});
    chk("selAll", 32'h0, {23'h0, ctl.counterSel});
    waitStep();
    wr(2'h2, 32'hc0000001);
    repeat (2) @(posedge sysClk);
    #1;
    chk("noStep", 32'h0, {31'h0, ctl.phaseStep});
    wr(2'h2, 32'h00000002);
    chk("noStep00", 32'h0, {31'h0, ctl.phaseStep});
    $display("test phase step done");
    wrap_up();
  end
endmodule
`default_nettype wire
